// file: verilog/ccr_map.svh
// register offsets, field positions, reset values and bus constants of the clock output control block
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_SLAVE_ADDR 7'h69
`define CCR_NUM_REGS 6
`define CCR_BLOCK_COUNT 8'h06

`define CCR_OFS_SRC_CPU2_EN 7'h00
`define CCR_OFS_MISC_SPREAD 7'h01
`define CCR_OFS_BUS_EN 7'h02
`define CCR_OFS_SRC_STOP_SEL 7'h03
`define CCR_OFS_FR_STOP_DOT_PD 7'h04
`define CCR_OFS_DRIVE_MODES 7'h05

`define CCR_RST_SRC_CPU2_EN 8'hFF
`define CCR_RST_MISC_SPREAD 8'hF6
`define CCR_RST_BUS_EN 8'hFF
`define CCR_RST_SRC_STOP_SEL 8'h00
`define CCR_RST_FR_STOP_DOT_PD 8'h07
`define CCR_RST_DRIVE_MODES 8'h00

// misc_output_and_spread_ctrl fields
`define CCR_B1_FREERUN0_EN 7
`define CCR_B1_DISPLAY_EN 6
`define CCR_B1_USB48_EN 5
`define CCR_B1_REF_EN 4
`define CCR_B1_SPREAD_CENTER 3
`define CCR_B1_CPU1_EN 2
`define CCR_B1_CPU0_EN 1
`define CCR_B1_SPREAD_ON 0
// bus_clock_output_enables fields
`define CCR_B2_BUS_EN_LSB 2
`define CCR_B2_FREERUN2_EN 1
`define CCR_B2_FREERUN1_EN 0
// freerun_stop_select_dot_pd fields
`define CCR_B4_DISPLAY_PD_HIZ 6
`define CCR_B4_FR_STOP_LSB 3
// stop_powerdown_drive_modes fields
`define CCR_B5_SRC_STOP_HIZ 7
`define CCR_B5_SRC_PD_HIZ 3
`define CCR_B5_CPU2_PD_HIZ 2
`define CCR_B5_CPU1_PD_HIZ 1
`define CCR_B5_CPU0_PD_HIZ 0

// output vector layout
`define CCR_NPAIR 10
`define CCR_NSE 11
`define CCR_PAIR_SHARED 9
`define CCR_PAIR_SRC_BASE 2
`define CCR_PAIR_DISPLAY 2
`define CCR_PAIR_CPU1 1
`define CCR_PAIR_CPU0 0
`define CCR_SE_REF 10
`define CCR_SE_USB48 9
`define CCR_SE_FREERUN_LSB 6
`define CCR_SE_BUS_LSB 0

`endif

// file: verilog/ccr_pkg.sv
// types shared by the clock output control block
`default_nettype none
`include "ccr_map.svh"
package ccr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CMD   = 3'b010,
    ST_COUNT = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_MACK  = 3'b110
  } ccr_state_t;

  typedef struct packed {
    logic [`CCR_NPAIR-1:0] drive;
    logic [`CCR_NPAIR-1:0] run;
  } ccr_pair_ctl_t;

  typedef struct packed {
    logic [`CCR_NSE-1:0] drive;
    logic [`CCR_NSE-1:0] run;
  } ccr_se_ctl_t;

endpackage : ccr_pkg
`default_nettype wire

// file: verilog/ccr_sync.sv
// two flip-flop synchronisers for pins from outside the mclk domain
`default_nettype none
module ccr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule : ccr_sync
`default_nettype wire

// file: verilog/ccr_outctl.sv
// per-output run and drive flops that only change in the low phase of the output clock
`default_nettype none
module ccr_outctl #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic phase_low,
  input wire logic [W-1:0] want_run,
  input wire logic [W-1:0] want_drive,
  output var logic [W-1:0] run,
  output var logic [W-1:0] drive
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_out
      logic next_run;
      logic next_drive;
      // changing only while the clock is low keeps every gated edge whole
      always_comb
      begin
        next_run = phase_low ? want_run[i] : run[i];
        next_drive = phase_low ? want_drive[i] : drive[i];
      end
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          run[i] <= 1'b0;
          drive[i] <= 1'b0;
        end
        else
        begin
          run[i] <= next_run;
          drive[i] <= next_drive;
        end
      end
    end
  endgenerate
endmodule : ccr_outctl
`default_nettype wire

// file: verilog/ccr_top.sv
// clock output control registers with their two-wire serial slave and output gating
`default_nettype none
`include "ccr_map.svh"

// Summary of operation
// - byte 0 bits 7..1 enable shared pair and src pairs 6..1; zero is Hi-Z
// - byte 1 bits 7,5,4 enable freerun clock 0, 48 MHz and reference clock
// - byte 1 bits 6,2,1 enable display pair, cpu1, cpu0; zero is Hi-Z
// - byte 1 bit 3 picks downspread (0) or centerspread (1); resets to zero
// - byte 1 bit 0 turns spread on; resets to off
// - byte 2 bits 7..2 enable bus clocks 5..0, bits 1,0 freerun 2,1
// - byte 3 bits 7..1 let the stop request halt src pairs 7..1
// - byte 4 bits 5..3 let the stop request halt freerun clocks 2..0
// - byte 4 bit 6 puts the display pair in Hi-Z during power-down
// - byte 5 bit 7 puts stopped src pairs in Hi-Z instead of driven low
// - byte 5 bit 3 puts all src pairs in Hi-Z during power-down
// - byte 5 bits 2..0 put cpu pairs 2..0 in Hi-Z during power-down
// - serial slave at D2h; command bit 7 byte access, bits 6:0 offset
// - all registers load defaults at reset, so no access is needed
// - stop and resume happen together, with no short pulses
// - during power-down, outputs not set to Hi-Z are driven low
module ccr_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic software_stop_request,
  input wire logic power_down_input,
  input wire logic stop_phase_ref,
  output ccr_pkg::ccr_pair_ctl_t pair_ctl,
  output ccr_pkg::ccr_se_ctl_t se_ctl,
  output logic spread_on,
  output logic spread_center
);
  import ccr_pkg::*;

  localparam logic [7:0] RST_VALS [0:`CCR_NUM_REGS-1] = '{
    `CCR_RST_SRC_CPU2_EN, `CCR_RST_MISC_SPREAD, `CCR_RST_BUS_EN,
    `CCR_RST_SRC_STOP_SEL, `CCR_RST_FR_STOP_DOT_PD, `CCR_RST_DRIVE_MODES};

  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic stop_s;
  logic pd_s;
  logic phase_s;

  // idle bus lines start high; the phase bit starts high too, so no output
  // switches after reset before a real low phase has been seen
  ccr_sync #(.W(5), .RST_VAL(5'h13)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign pins_raw = {stop_phase_ref, power_down_input, software_stop_request, sda_in, scl};
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign stop_s = pins_s[2];
  assign pd_s = pins_s[3];
  assign phase_s = pins_s[4];

  ccr_state_t state;
  ccr_state_t next_state;
  logic [7:0] regs [0:`CCR_NUM_REGS-1];
  logic [7:0] next_regs [0:`CCR_NUM_REGS-1];
  logic scl_q;
  logic sda_q;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [6:0] ptr;
  logic [6:0] next_ptr;
  logic rw;
  logic next_rw;
  logic byte_mode;
  logic next_byte_mode;
  logic cnt_sent;
  logic next_cnt_sent;
  logic ack_pend;
  logic next_ack_pend;
  logic in_ack;
  logic next_in_ack;
  logic next_sda_oe;

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rx_byte;
  logic [7:0] rd_val;
  logic [7:0] load_val;
  logic do_load;

  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign rx_byte = {shreg[6:0], sda_s};
  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;

  // offsets past the last register read as zero
  always_comb
  begin
    rd_val = 8'h00;
    for (int i = 0; i < `CCR_NUM_REGS; i++)
    begin
      if (ptr == 7'(i))
        rd_val = regs[i];
    end
  end

  // a block read sends the byte count before the first register
  assign load_val = (!byte_mode && !cnt_sent) ? `CCR_BLOCK_COUNT : rd_val;

  always_comb
  begin
    next_state = state;
    next_regs = regs;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_byte_mode = byte_mode;
    next_cnt_sent = cnt_sent;
    next_ack_pend = ack_pend;
    next_in_ack = in_ack;
    next_sda_oe = sda_oe;
    do_load = 1'b0;
    if (start_cond)
    begin
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_ack_pend = 1'b0;
      next_in_ack = 1'b0;
    end
    else if (stop_cond)
    begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
      next_ack_pend = 1'b0;
      next_in_ack = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA:
        begin
          if (scl_rise && !ack_pend && !in_ack)
          begin
            next_shreg = rx_byte;
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7)
            begin
              next_bitcnt = 4'h0;
              next_ack_pend = 1'b1;
              if (state == ST_ADDR)
              begin
                if (rx_byte[7:1] != `CCR_SLAVE_ADDR)
                begin
                  next_state = ST_IDLE;
                  next_ack_pend = 1'b0;
                end
                next_rw = rx_byte[0];
              end
              else if (state == ST_CMD)
              begin
                next_byte_mode = rx_byte[7];
                next_ptr = rx_byte[7] ? rx_byte[6:0] : 7'h00;
                next_cnt_sent = 1'b0;
              end
              else if (state == ST_WDATA)
              begin
                for (int i = 0; i < `CCR_NUM_REGS; i++)
                begin
                  if (ptr == 7'(i))
                    next_regs[i] = rx_byte;
                end
                next_ptr = ptr + 7'h01;
              end
            end
          end
          else if (scl_fall && ack_pend)
          begin
            next_sda_oe = 1'b1;
            next_ack_pend = 1'b0;
            next_in_ack = 1'b1;
          end
          else if (scl_fall && in_ack)
          begin
            next_in_ack = 1'b0;
            next_sda_oe = 1'b0;
            if (state == ST_ADDR && rw)
              do_load = 1'b1;
            else if (state == ST_ADDR)
              next_state = ST_CMD;
            else if (state == ST_CMD && !byte_mode)
              next_state = ST_COUNT;
            else
              next_state = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_sda_oe = 1'b0;
              next_state = ST_MACK;
            end
            else
            begin
              next_sda_oe = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            // a not-acknowledge ends the read
            if (sda_s)
              next_state = ST_IDLE;
            else
              next_ack_pend = 1'b1;
          end
          else if (scl_fall && ack_pend)
          begin
            next_ack_pend = 1'b0;
            do_load = 1'b1;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    if (do_load)
    begin
      next_state = ST_RDATA;
      next_sda_oe = ~load_val[7];
      next_shreg = {load_val[6:0], 1'b0};
      next_bitcnt = 4'h1;
      if (!byte_mode && !cnt_sent)
        next_cnt_sent = 1'b1;
      else
        next_ptr = ptr + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      for (int i = 0; i < `CCR_NUM_REGS; i++)
        regs[i] <= RST_VALS[i];
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 7'h00;
      rw <= 1'b0;
      byte_mode <= 1'b0;
      cnt_sent <= 1'b0;
      ack_pend <= 1'b0;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      regs <= next_regs;
      scl_q <= scl_s;
      sda_q <= sda_s;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      byte_mode <= next_byte_mode;
      cnt_sent <= next_cnt_sent;
      ack_pend <= next_ack_pend;
      in_ack <= next_in_ack;
      sda_oe <= next_sda_oe;
    end
  end

  logic [`CCR_NPAIR-1:0] pair_want_run;
  logic [`CCR_NPAIR-1:0] pair_want_drive;
  logic [`CCR_NSE-1:0] se_want_run;
  logic [`CCR_NSE-1:0] se_want_drive;
  logic [2:0] fr_en;
  logic fr_stopped;
  logic src_stopped;
  logic pd_hiz;

  always_comb
  begin
    fr_en = {regs[2][`CCR_B2_FREERUN2_EN], regs[2][`CCR_B2_FREERUN1_EN],
      regs[1][`CCR_B1_FREERUN0_EN]};
    fr_stopped = 1'b0;
    src_stopped = 1'b0;
    pd_hiz = 1'b0;
    pair_want_run = '0;
    pair_want_drive = '0;
    // src pair k sits at vector index k+2; index 9 is the shared pair
    for (int k = 1; k <= 7; k++)
    begin
      src_stopped = stop_s & regs[3][k];
      pd_hiz = regs[5][`CCR_B5_SRC_PD_HIZ] | ((k == 7) & regs[5][`CCR_B5_CPU2_PD_HIZ]);
      pair_want_run[k + 2] = regs[0][k] & ~pd_s & ~src_stopped;
      pair_want_drive[k + 2] = regs[0][k] & ~(pd_s & pd_hiz) &
        ~(src_stopped & regs[5][`CCR_B5_SRC_STOP_HIZ]);
    end
    pair_want_run[`CCR_PAIR_DISPLAY] = regs[1][`CCR_B1_DISPLAY_EN] & ~pd_s;
    pair_want_drive[`CCR_PAIR_DISPLAY] = regs[1][`CCR_B1_DISPLAY_EN] &
      ~(pd_s & regs[4][`CCR_B4_DISPLAY_PD_HIZ]);
    pair_want_run[`CCR_PAIR_CPU1] = regs[1][`CCR_B1_CPU1_EN] & ~pd_s;
    pair_want_drive[`CCR_PAIR_CPU1] = regs[1][`CCR_B1_CPU1_EN] &
      ~(pd_s & regs[5][`CCR_B5_CPU1_PD_HIZ]);
    pair_want_run[`CCR_PAIR_CPU0] = regs[1][`CCR_B1_CPU0_EN] & ~pd_s;
    pair_want_drive[`CCR_PAIR_CPU0] = regs[1][`CCR_B1_CPU0_EN] &
      ~(pd_s & regs[5][`CCR_B5_CPU0_PD_HIZ]);
    // single-ended outputs are never released; disabled or stopped means held low
    se_want_drive = '1;
    se_want_run = '0;
    for (int b = 0; b < 6; b++)
      se_want_run[`CCR_SE_BUS_LSB + b] = regs[2][`CCR_B2_BUS_EN_LSB + b] & ~pd_s & ~stop_s;
    for (int f = 0; f < 3; f++)
    begin
      fr_stopped = stop_s & regs[4][`CCR_B4_FR_STOP_LSB + f];
      se_want_run[`CCR_SE_FREERUN_LSB + f] = fr_en[f] & ~pd_s & ~fr_stopped;
    end
    se_want_run[`CCR_SE_USB48] = regs[1][`CCR_B1_USB48_EN] & ~pd_s;
    se_want_run[`CCR_SE_REF] = regs[1][`CCR_B1_REF_EN] & ~pd_s;
  end

  // one shared phase reference makes all stoppable outputs switch on the same edge
  ccr_outctl #(.W(`CCR_NPAIR)) u_pair_ctl (
    .mclk(mclk),
    .rst_n(rst_n),
    .phase_low(~phase_s),
    .want_run(pair_want_run),
    .want_drive(pair_want_drive),
    .run(pair_ctl.run),
    .drive(pair_ctl.drive)
  );

  ccr_outctl #(.W(`CCR_NSE)) u_se_ctl (
    .mclk(mclk),
    .rst_n(rst_n),
    .phase_low(~phase_s),
    .want_run(se_want_run),
    .want_drive(se_want_drive),
    .run(se_ctl.run),
    .drive(se_ctl.drive)
  );

  assign spread_on = regs[1][`CCR_B1_SPREAD_ON];
  assign spread_center = regs[1][`CCR_B1_SPREAD_CENTER];
endmodule : ccr_top
`default_nettype wire

// file: test/ccr_properties.sv
// port-level assertions for the clock output control block
`default_nettype none
module ccr_properties
  import ccr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic software_stop_request,
  input wire logic power_down_input,
  input wire logic stop_phase_ref,
  input wire ccr_pkg::ccr_pair_ctl_t pair_ctl,
  input wire ccr_pkg::ccr_se_ctl_t se_ctl,
  input wire logic spread_on,
  input wire logic spread_center
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // the phase pin passes two sync flops, so allow either sample
  property p_pair_phase;
    !$stable(pair_ctl) |-> !($past(stop_phase_ref, 2) && $past(stop_phase_ref, 3));
  endproperty
  a_pair_phase: assert property (p_pair_phase) else $error("pair change in high phase");
  property p_se_phase;
    !$stable(se_ctl) |-> !($past(stop_phase_ref, 2) && $past(stop_phase_ref, 3));
  endproperty
  a_se_phase: assert property (p_se_phase) else $error("single-ended change in high phase");
  property p_stop_bus;
    (software_stop_request && !stop_phase_ref) [*6] |-> se_ctl.run[5:0] == 6'h00;
  endproperty
  a_stop_bus: assert property (p_stop_bus) else $error("bus clocks run under stop");
  property p_pd_low;
    (power_down_input && !stop_phase_ref) [*6] |-> se_ctl.run == 11'h000 && (pair_ctl.run & pair_ctl.drive) == 10'h000;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("output runs in power-down");
  property p_se_drive;
    (!stop_phase_ref) [*6] |-> se_ctl.drive == 11'h7FF;
  endproperty
  a_se_drive: assert property (p_se_drive) else $error("single-ended output not driven");
  property p_ack_rise;
    $rose(sda_oe) |-> !$past(scl, 2);
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("data pulled while clock high");
  property p_oe_hold;
    scl [*4] |-> $stable(sda_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved while clock high");
  property p_spread_upd;
    $changed(spread_on) || $changed(spread_center) |-> $past(scl, 3);
  endproperty
  a_spread_upd: assert property (p_spread_upd) else $error("spread moved outside a bit");
endmodule : ccr_properties
bind ccr_top ccr_properties u_props (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_oe(sda_oe),
  .software_stop_request(software_stop_request), .power_down_input(power_down_input),
  .stop_phase_ref(stop_phase_ref), .pair_ctl(pair_ctl), .se_ctl(se_ctl), .spread_on(spread_on),
  .spread_center(spread_center));
`default_nettype wire

// file: test/ccr_host.sv
// serial bus host model: drives the clock and drives data high or low on sda_m
`default_nettype none
module ccr_host (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // data moves mid-low, sampled mid-high: 160 ns per bit
  task automatic bit_io(input logic b, output logic r);
    #40 sda_m = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #40 sda_m = 1'b1;
    #40 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl = 1'b0;
  endtask : start
  task automatic stop();
    #40 sda_m = 1'b0;
    #40 scl = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(a, k);
  endtask : xfer
endmodule : ccr_host
`default_nettype wire

// file: test/test_ccr_top.sv
// self-checking bench for the clock output control block
`default_nettype none
module test_ccr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  logic mclk, rst_n, stop_req, pd_in, phase_ref, scl, sda_m, sda_out, sda_oe, spread_on, spread_center, k;
  wire logic sda;
  ccr_pair_ctl_t pair_ctl;
  ccr_se_ctl_t se_ctl;
  logic [7:0] regs [0:5];
  logic [7:0] rd;
  int bad_count, compares;
  // byte 3 stops src pairs 6 and 4, which byte 0 enables, and leaves src 2 running
  localparam logic [47:0] BYTE_VALS = 48'h55_09_AA_50_7F_0F;
  assign sda = sda_oe ? sda_out : sda_m;
  ccr_top DUT (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .software_stop_request(stop_req), .power_down_input(pd_in), .stop_phase_ref(phase_ref),
    .pair_ctl(pair_ctl), .se_ctl(se_ctl), .spread_on(spread_on), .spread_center(spread_center));
  ccr_host host (.scl(scl), .sda_m(sda_m), .sda(sda));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    phase_ref = 1'b0;
    forever #80 phase_ref = ~phase_ref;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    host.start();
    host.xfer(8'hD2, 1'b1, rd, k);
    host.xfer({1'b1, ofs}, 1'b1, rd, k);
    host.xfer(d, 1'b1, rd, k);
    check(k, 1'b0);
    host.stop();
    if (ofs < 7'h06)
      regs[ofs] = d;
  endtask : wr
  task automatic rdb(input logic [6:0] ofs, output logic [7:0] d);
    host.start();
    host.xfer(8'hD2, 1'b1, d, k);
    host.xfer({1'b1, ofs}, 1'b1, d, k);
    host.start();
    host.xfer(8'hD3, 1'b1, d, k);
    host.xfer(8'hFF, 1'b1, d, k);
    host.stop();
  endtask : rdb
  task automatic blk_rd();
    logic [7:0] d;
    host.start();
    host.xfer(8'hD2, 1'b1, d, k);
    host.xfer(8'h00, 1'b1, d, k);
    host.start();
    host.xfer(8'hD3, 1'b1, d, k);
    host.xfer(8'hFF, 1'b0, d, k);
    check(d, 8'h06);
    for (int i = 0; i < 6; i++)
    begin
      host.xfer(8'hFF, i == 5, d, k);
      check(d, regs[i]);
    end
    host.stop();
  endtask : blk_rd
  task automatic blk_wr(input logic [47:0] v);
    host.start();
    host.xfer(8'hD2, 1'b1, rd, k);
    host.xfer(8'h00, 1'b1, rd, k);
    host.xfer(8'h06, 1'b1, rd, k);
    for (int i = 0; i < 6; i++)
    begin
      regs[i] = v[47-8*i -: 8];
      host.xfer(regs[i], 1'b1, rd, k);
    end
    host.stop();
  endtask : blk_wr
  // expected outputs from the register image; Hi-Z pairs have no run to check
  task automatic outs(input logic st, input logic pd);
    logic [9:0] en, sm, hz, dv;
    logic [10:0] se;
    en = {regs[0][7:1], regs[1][6], regs[1][2], regs[1][1]};
    sm = st ? {regs[3][7:1], 3'b000} : 10'h000;
    hz = {{7{regs[5][3]}}, regs[4][6], regs[5][1], regs[5][0]};
    hz[9] = hz[9] | regs[5][2];
    dv = en & ~(sm & {10{regs[5][7]}}) & ~(pd ? hz : 10'h000);
    se = {regs[1][4], regs[1][5], regs[2][1:0], regs[1][7], regs[2][7:2]};
    se = se & ~(st ? {2'b00, regs[4][5:3], 6'h3F} : 11'h000) & {11{~pd}};
    repeat (40) @(negedge mclk);
    check(pair_ctl.drive, dv);
    check(pair_ctl.run & pair_ctl.drive, en & ~sm & {10{~pd}});
    check(se_ctl.run, se);
    check(se_ctl.drive, 11'h7FF);
    check({spread_center, spread_on}, {regs[1][3], regs[1][0]});
  endtask : outs
  initial
  begin
    #600us;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    stop_req = 1'b0;
    pd_in = 1'b0;
    bad_count = 0;
    compares = 0;
    regs = '{8'hFF, 8'hF6, 8'hFF, 8'h00, 8'h07, 8'h00};
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 6; i++)
    begin
      rdb(i[6:0], rd);
      check(rd, regs[i]);
    end
    outs(1'b0, 1'b0);
    blk_rd();
    $display("test defaults done");
    for (int i = 0; i < 6; i++)
      wr(i[6:0], BYTE_VALS[47 - 8 * i -: 8]);
    blk_rd();
    outs(1'b0, 1'b0);
    $display("test byte writes done");
    stop_req = 1'b1;
    outs(1'b1, 1'b0);
    wr(7'h05, 8'h8F);
    outs(1'b1, 1'b0);
    stop_req = 1'b0;
    outs(1'b0, 1'b0);
    $display("test stop done");
    // enable every pair so that the power-down drive modes show
    wr(7'h00, 8'hFF);
    wr(7'h01, 8'h47);
    pd_in = 1'b1;
    outs(1'b0, 1'b1);
    wr(7'h05, 8'h04);
    outs(1'b0, 1'b1);
    pd_in = 1'b0;
    outs(1'b0, 1'b0);
    $display("test power-down done");
    host.start();
    host.xfer(8'hD4, 1'b1, rd, k);
    check(k, 1'b1);
    host.stop();
    wr(7'h06, 8'h5A);
    rdb(7'h06, rd);
    check(rd, 8'h00);
    blk_wr(48'h81_F7_03_FE_3F_0C);
    blk_rd();
    outs(1'b0, 1'b0);
    $display("test refusals and block write done");
    tally_and_finish();
  end
endmodule : test_ccr_top
`default_nettype wire
